//--- bench/core_model.sv
// core side model: bus master issuing register transfers
`timescale 1ns/100ps
module core_model
  import tick_pkg::*;
(
  // clock
  input wire logic clk,
  // register bus
  output tick_pkg::avs_req_s avs_req,
  input wire tick_pkg::avs_rsp_s avs_rsp
);
  initial avs_req <= '0;
  // one transfer; held until waitrequest is seen low, then an idle edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input word_t d,
                      input logic [LANES-1:0] be, output word_t q);
    avs_req.write <= w;
    avs_req.read <= !w;
    avs_req.address <= a;
    avs_req.byteenable <= be;
    avs_req.writedata <= d;
    @(posedge clk);
    while (avs_rsp.waitrequest !== 1'b0) @(posedge clk);
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
    // idle edge so back to back calls never drive a strobe twice at once
    @(posedge clk);
  endtask : xfer
endmodule : core_model

//--- bench/tb_core_system_tick_counter.sv
// self-checking bench for the system tick counter
`timescale 1ns/100ps
module tb_core_system_tick_counter;
  import tick_pkg::*;
  logic clk;
  logic rst;
  avs_req_s avs_req;
  avs_rsp_s avs_rsp;
  logic counter_irq;
  logic software_interrupt;
  logic irq;
  int fails;
  int checks_done;
  int seed;
  word_t v1;
  word_t v2;
  word_t r;
  logic [LANES-1:0] be_r;

  core_system_tick_counter i_core_system_tick_counter (.clk(clk), .rst(rst),
    .avs_req(avs_req), .avs_rsp(avs_rsp), .counter_irq(counter_irq),
    .software_interrupt(software_interrupt), .irq(irq));
  core_model i_core_model (.clk(clk), .avs_req(avs_req), .avs_rsp(avs_rsp));

  task automatic wr(input logic [ADDR_W-1:0] a, input word_t d);
    word_t q;
    i_core_model.xfer(1'b1, a, d, 4'hf, q);
  endtask : wr
  // write that reaches only the chosen byte lanes
  task automatic wr_be(input logic [ADDR_W-1:0] a, input word_t d, input logic [LANES-1:0] be);
    word_t q;
    i_core_model.xfer(1'b1, a, d, be, q);
  endtask : wr_be
  task automatic rd(input logic [ADDR_W-1:0] a, output word_t q);
    i_core_model.xfer(1'b0, a, ZERO_WORD, 4'hf, q);
  endtask : rd
  // expected word after a lane-selective write
  function automatic word_t lane_mix(word_t old_w, word_t new_w, logic [LANES-1:0] be);
    word_t res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
    end
    return res;
  endfunction : lane_mix
  task automatic check_word(input word_t got, input word_t exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bit
  // two back to back read snapshots lie three clocks apart
  function automatic word_t next_seen(word_t v, logic down, word_t period, int ticks);
    if (down) return v - ticks;
    if (period == ZERO_WORD) return v + ticks;
    return (v + ticks) % period;
  endfunction : next_seen
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog, generous against a run of a few hundred clocks
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end
  // main sequence
  initial begin
    seed = 32'h2092_40a6;
    fails = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // every offset reads zero after reset, the hole at 0x0C included
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), r);
      check_word(r, ZERO_WORD);
    end
    // random round trips while the counter is off, plus unmapped and lane writes
    for (int i = 0; i < 4; i++) begin
      v1 = $random(seed);
      v2 = $random(seed);
      be_r = 4'($random(seed));
      wr(OFS_COUNT, v1);
      wr(OFS_COMPARE, v2);
      wr(5'h0C, v1);
      rd(OFS_COUNT, r);
      check_word(r, v1);
      rd(OFS_COMPARE, r);
      check_word(r, v2);
      rd(5'h0C, r);
      check_word(r, ZERO_WORD);
      wr_be(OFS_COUNT, v2, be_r);
      rd(OFS_COUNT, r);
      check_word(r, lane_mix(v1, v2, be_r));
    end
    wr(OFS_CONTROL, 32'h7FFF_FFF0);
    rd(OFS_CONTROL, r);
    check_word(r, ZERO_WORD);
    // fast up count runs past a small compare value
    wr(OFS_COMPARE, 32'h0000_0004);
    wr(OFS_COUNT, ZERO_WORD);
    wr(OFS_CONTROL, 32'h0000_0005);
    rd(OFS_COUNT, v1);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_COUNT, v2);
      check_word(v2, next_seen(v1, 1'b0, ZERO_WORD, 3));
      v1 = v2;
    end
    // slow time base: eight reads span 24 clocks, three ticks
    wr(OFS_CONTROL, 32'h0000_0001);
    rd(OFS_COUNT, v1);
    for (int i = 0; i < 8; i++) rd(OFS_COUNT, r);
    check_word(r, next_seen(v1, 1'b0, ZERO_WORD, 3));
    // down count wraps through zero
    wr(OFS_DIRECTION, 32'h0000_0001);
    wr(OFS_COUNT, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_0005);
    rd(OFS_COUNT, v1);
    rd(OFS_COUNT, v2);
    check_word(v2, next_seen(v1, 1'b1, ZERO_WORD, 3));
    // auto reload at compare value ten gives a period of eleven
    wr(OFS_CONTROL, ZERO_WORD);
    wr(OFS_DIRECTION, ZERO_WORD);
    wr(OFS_COMPARE, 32'h0000_000A);
    wr(OFS_COUNT, ZERO_WORD);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0000_000F);
    for (int i = 0; i < 6; i++) begin
      rd(OFS_COUNT, v1);
      rd(OFS_COUNT, v2);
      check_word(v2, next_seen(v1, 1'b0, 32'h0000_000B, 3));
    end
    check_bit(counter_irq, 1'b1);
    check_bit(irq, 1'b1);
    // stop counting so no new match races the flag clear
    wr(OFS_CONTROL, 32'h0000_0002);
    rd(OFS_STATUS, r);
    check_word(r, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0001);
    rd(OFS_STATUS, r);
    check_word(r, 32'h0000_0001);
    wr(OFS_STATUS, ZERO_WORD);
    rd(OFS_STATUS, r);
    check_word(r, ZERO_WORD);
    check_bit(counter_irq, 1'b0);
    wr(OFS_IRQ_MASK, ZERO_WORD);
    check_bit(irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    check_bit(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h0000_0001);
    check_bit(irq, 1'b0);
    // match with the counter request disabled
    wr(OFS_CONTROL, 32'h0000_000D);
    for (int i = 0; i < 5; i++) rd(OFS_COUNT, r);
    rd(OFS_STATUS, r);
    check_word(r, 32'h0000_0001);
    check_bit(counter_irq, 1'b0);
    // software request stays until the handler clears it
    wr(OFS_CONTROL, 32'h8000_0000);
    check_bit(software_interrupt, 1'b1);
    rd(OFS_CONTROL, r);
    check_word(r, 32'h8000_0000);
    rd(OFS_IRQ_STATUS, r);
    check_word(r, 32'h0000_0003);
    check_bit(software_interrupt, 1'b1);
    wr(OFS_CONTROL, ZERO_WORD);
    check_bit(software_interrupt, 1'b0);
    wr(OFS_IRQ_STATUS, 32'h0000_0003);
    rd(OFS_IRQ_STATUS, r);
    check_word(r, ZERO_WORD);
    check_bit(irq, 1'b0);
    // reset in mid-run clears control, count and the software interrupt output
    wr(OFS_CONTROL, 32'h8000_000F);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_bit(software_interrupt, 1'b0);
    rd(OFS_CONTROL, r);
    check_word(r, ZERO_WORD);
    rd(OFS_COUNT, r);
    check_word(r, ZERO_WORD);
    final_report();
  end
endmodule : tb_core_system_tick_counter

//--- bench/tick_chk.sv
// assertion checker for the tick counter bus answers and interrupt outputs
`timescale 1ns/100ps
module tick_chk
  import tick_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire tick_pkg::avs_req_s avs_req,
  input wire tick_pkg::avs_rsp_s avs_rsp,
  // interrupts
  input wire logic counter_irq,
  input wire logic software_interrupt,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // accepted transfers
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = avs_req.write && !avs_rsp.waitrequest;
  assign rd_ok = avs_req.read && !avs_rsp.waitrequest;
  AST_ONE_WAIT: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("answer not after one wait cycle");
  AST_SHORT_ANSWER: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
    else $error("answer held too long");
  AST_SOFT_ON: assert property (wr_ok && avs_req.address == OFS_CONTROL && avs_req.writedata[31]
    |=> software_interrupt [*2]) else $error("soft request not raised");
  AST_SOFT_OFF: assert property (wr_ok && avs_req.address == OFS_CONTROL && !avs_req.writedata[31]
    |=> !software_interrupt) else $error("soft request not dropped");
  AST_SOFT_CAUSE: assert property ($rose(software_interrupt)
    |-> $past(wr_ok && avs_req.address == OFS_CONTROL)) else $error("soft request without write");
  AST_IRQ_GATE: assert property (wr_ok && avs_req.address == OFS_CONTROL && !avs_req.writedata[1]
    |=> !counter_irq) else $error("counter request not gated");
  AST_STAT_RSV: assert property (rd_ok && avs_req.address == OFS_STATUS
    |-> avs_rsp.readdata[31:1] == 31'h0000_0000) else $error("status reserved bits set");
  AST_CTL_RSV: assert property (rd_ok && avs_req.address == OFS_CONTROL
    |-> avs_rsp.readdata[30:4] == 27'h000_0000) else $error("control reserved bits set");
  AST_HOLE: assert property (rd_ok && avs_req.address == 5'h0C
    |-> avs_rsp.readdata == ZERO_WORD) else $error("unmapped read not zero");
  AST_MASK_OFF: assert property (wr_ok && avs_req.address == OFS_IRQ_MASK
    && avs_req.writedata[1:0] == 2'h0 |=> !irq) else $error("masked interrupt seen");
  // main scenarios reached
  cover property ($rose(software_interrupt));
  cover property ($rose(counter_irq));
  cover property ($fell(irq));
endmodule : tick_chk

bind core_system_tick_counter tick_chk i_tick_chk (.clk(clk), .rst(rst), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .counter_irq(counter_irq), .software_interrupt(software_interrupt),
  .irq(irq));

//--- logic/core_system_tick_counter.sv
// system tick counter with avalon-mm register slave and interrupt outputs
//
// Behaviour
// R1: software interrupt stays asserted while its control bit is set; software clears it.
// R2: with auto-reload, up count restarts from zero after reaching the compare value.
// R3: without auto-reload, up count keeps incrementing past the compare value.
// R4: without auto-reload, down count wraps from zero to all ones.
// R5: time base select one uses bus clock, zero uses bus clock over eight.
// R6: counter interrupt enable bit permits or suppresses the counter interrupt request.
// R7: counter enable bit starts counting; clear holds the value; resets to zero.
// R8: compare-match flag sets when up count reaches compare; else reads zero.
// R9: writing zero clears the match flag, one leaves it; other status bits zero.
// R10: count is 32 bits, read and write at offset 0x08, resets zero.
// R11: compare is 32 bits, read and write, resets zero, used by match and reload.
// R12: counter interrupt request is high while match flag and enable are both set.
// R13: count steps by one per tick; a bus write overrides that cycle's step.
`timescale 1ns/100ps
module core_system_tick_counter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire tick_pkg::avs_req_s avs_req,
  output tick_pkg::avs_rsp_s avs_rsp,
  // interrupt requests to the core
  output logic counter_irq,
  output logic software_interrupt,
  output logic irq
);
  import tick_pkg::*;

  // merge write data into an old word lane by lane
  function automatic word_t merge_lanes(input word_t old_w, input word_t new_w,
                                        input logic [LANES-1:0] be);
    word_t res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  // register state
  control_s control_q;
  control_s control_d;
  word_t count_q;
  word_t count_d;
  word_t compare_q;
  word_t compare_d;
  logic match_flag_q;
  logic match_flag_d;
  logic count_down_q;
  logic count_down_d;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_status_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_mask_d;

  // bus answer and interrupt output state
  avs_rsp_s rsp_q;
  avs_rsp_s rsp_d;
  logic counter_irq_q;
  logic counter_irq_d;
  logic soft_irq_q;
  logic soft_irq_d;
  logic irq_q;
  logic irq_d;

  // decode and event wires
  logic access;
  logic accept;
  logic wr_en;
  logic sel_control;
  logic sel_status;
  logic sel_count;
  logic sel_compare;
  logic sel_irq_status;
  logic sel_irq_mask;
  logic sel_direction;
  logic tick;
  logic match_hit;
  logic match_clear;
  word_t control_word;
  word_t ctl_wr;
  word_t rd_mux;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_clear;

  // bus decode: waitrequest idles high and drops for the single accepting cycle
  assign access = avs_req.read || avs_req.write;
  assign accept = access && !rsp_q.waitrequest;
  assign wr_en = avs_req.write && accept;
  assign sel_control = (avs_req.address == OFS_CONTROL);
  assign sel_status = (avs_req.address == OFS_STATUS);
  assign sel_count = (avs_req.address == OFS_COUNT);
  assign sel_compare = (avs_req.address == OFS_COMPARE);
  assign sel_irq_status = (avs_req.address == OFS_IRQ_STATUS);
  assign sel_irq_mask = (avs_req.address == OFS_IRQ_MASK);
  assign sel_direction = (avs_req.address == OFS_DIRECTION);

  // control register seen as a bus word, reserved bits zero
  always_comb begin
    control_word = ZERO_WORD;
    control_word[CTL_SOFT_IRQ_BIT] = control_q.soft_irq_request;
    control_word[CTL_RELOAD_BIT] = control_q.auto_reload_enable;
    control_word[CTL_TBSEL_BIT] = control_q.time_base_select;
    control_word[CTL_IRQ_EN_BIT] = control_q.counter_irq_enable;
    control_word[CTL_ENABLE_BIT] = control_q.counter_enable;
  end

  // time base, held at rest while the counter is off
  // its tick is combinational, so clearing the enable stops the very next step
  tick_prescaler u_prescaler (
    .clk(clk),
    .rst(rst),
    .enable(control_q.counter_enable), // see R7
    .fast_select(control_q.time_base_select), // see R5
    .tick(tick)
  );

  // control and configuration registers
  // only the control bits that exist are stored; reserved bits are dropped on write
  always_comb begin
    control_d = control_q;
    compare_d = compare_q;
    count_down_d = count_down_q;
    irq_mask_d = irq_mask_q;
    ctl_wr = merge_lanes(control_word, avs_req.writedata, avs_req.byteenable);
    if (wr_en && sel_control) begin
      control_d.soft_irq_request = ctl_wr[CTL_SOFT_IRQ_BIT]; // see R1
      control_d.auto_reload_enable = ctl_wr[CTL_RELOAD_BIT];
      control_d.time_base_select = ctl_wr[CTL_TBSEL_BIT]; // see R5
      control_d.counter_irq_enable = ctl_wr[CTL_IRQ_EN_BIT]; // see R6
      control_d.counter_enable = ctl_wr[CTL_ENABLE_BIT]; // see R7
    end
    if (wr_en && sel_compare) begin
      compare_d = merge_lanes(compare_q, avs_req.writedata, avs_req.byteenable); // see R11
    end
    if (wr_en && sel_direction && avs_req.byteenable[0]) begin
      count_down_d = avs_req.writedata[DIR_DOWN_BIT];
    end
    if (wr_en && sel_irq_mask && avs_req.byteenable[0]) begin
      irq_mask_d = avs_req.writedata[IRQ_W-1:0];
    end
  end

  // configuration registers; reset leaves the counter off and every field zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q <= CONTROL_RST; // see R7
      compare_q <= COMPARE_RST; // see R11
      count_down_q <= 1'b0;
      irq_mask_q <= IRQ_RST;
    end else begin
      control_q <= control_d;
      compare_q <= compare_d;
      count_down_q <= count_down_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // counter: steps only on a tick, and a bus write wins over the step
  // down counting never raises the match flag, even with auto-reload set
  // the match test uses the count before the step, so compare itself is reached
  always_comb begin
    count_d = count_q;
    match_hit = 1'b0;
    if (tick) begin
      if (count_down_q) begin
        // natural 32-bit wrap takes zero to all ones
        count_d = count_q - COUNT_STEP; // see R4
      end else if (count_q == compare_q) begin
        match_hit = 1'b1; // see R8
        if (control_q.auto_reload_enable) begin
          count_d = COUNT_RST; // see R2
        end else begin
          count_d = count_q + COUNT_STEP; // see R3
        end
      end else begin
        count_d = count_q + COUNT_STEP; // see R13
      end
    end
    if (wr_en && sel_count) begin
      count_d = merge_lanes(count_q, avs_req.writedata, avs_req.byteenable); // see R10, R13
    end
  end

  // count register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= COUNT_RST; // see R10
    end else begin
      count_q <= count_d;
    end
  end

  // match flag: write zero clears, write one ignored, a new match wins over the clear
  assign match_clear = wr_en && sel_status && avs_req.byteenable[0] &&
                       !avs_req.writedata[STAT_MATCH_BIT]; // see R9

  always_comb begin
    match_flag_d = match_hit || (match_flag_q && !match_clear); // see R8, R9
  end

  // flag register, kept apart so its clear cannot disturb the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_flag_q <= 1'b0;
    end else begin
      match_flag_q <= match_flag_d;
    end
  end

  // sticky interrupt status, write one to clear, events win over the clear
  always_comb begin
    irq_event = IRQ_RST;
    irq_event[IRQ_MATCH_BIT] = match_hit;
    irq_event[IRQ_SOFT_BIT] = control_q.soft_irq_request;
    irq_clear = IRQ_RST;
    if (wr_en && sel_irq_status && avs_req.byteenable[0]) begin
      irq_clear = avs_req.writedata[IRQ_W-1:0];
    end
    irq_status_d = irq_event | (irq_status_q & ~irq_clear);
  end

  // interrupt status register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= IRQ_RST;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // read mux; unmapped offsets read zero
  // decoding the raw address keeps misaligned offsets harmless: they miss every select
  always_comb begin
    rd_mux = ZERO_WORD;
    if (sel_control) begin
      rd_mux = control_word;
    end else if (sel_status) begin
      rd_mux[STAT_MATCH_BIT] = match_flag_q; // see R8, R9
    end else if (sel_count) begin
      rd_mux = count_q; // see R10
    end else if (sel_compare) begin
      rd_mux = compare_q; // see R11
    end else if (sel_irq_status) begin
      rd_mux[IRQ_W-1:0] = irq_status_q;
    end else if (sel_irq_mask) begin
      rd_mux[IRQ_W-1:0] = irq_mask_q;
    end else if (sel_direction) begin
      rd_mux[DIR_DOWN_BIT] = count_down_q;
    end
  end

  // answer one cycle after the request shows; data is a snapshot of that first cycle
  // limitation: a count read is one cycle old when the master takes it
  always_comb begin
    rsp_d = rsp_q;
    rsp_d.waitrequest = !(access && rsp_q.waitrequest);
    rsp_d.readdata = ZERO_WORD;
    if (avs_req.read && rsp_q.waitrequest) begin
      rsp_d.readdata = rd_mux;
    end
  end

  // bus answer register; waitrequest comes up high out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q <= AVS_RSP_RST;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // interrupt outputs from next-state values so they track their cause with one flop
  always_comb begin
    counter_irq_d = match_flag_d && control_d.counter_irq_enable; // see R6, R12
    soft_irq_d = control_d.soft_irq_request; // see R1
    irq_d = |(irq_status_d & irq_mask_d);
  end

  // interrupt output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_irq_q <= 1'b0;
      soft_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      counter_irq_q <= counter_irq_d;
      soft_irq_q <= soft_irq_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign avs_rsp = rsp_q;
  assign counter_irq = counter_irq_q;
  assign software_interrupt = soft_irq_q;
  assign irq = irq_q;

endmodule : core_system_tick_counter

//--- logic/tick_pkg.sv
// shared constants, register map and carrier types for the system tick counter
package tick_pkg;

  // data path widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h1C;

  // control register field positions
  localparam int CTL_SOFT_IRQ_BIT = 31;
  localparam int CTL_RELOAD_BIT = 3;
  localparam int CTL_TBSEL_BIT = 2;
  localparam int CTL_IRQ_EN_BIT = 1;
  localparam int CTL_ENABLE_BIT = 0;

  // status, interrupt and direction field positions
  localparam int STAT_MATCH_BIT = 0;
  localparam int IRQ_W = 2;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_SOFT_BIT = 1;
  localparam int DIR_DOWN_BIT = 0;

  // reset values and count step
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COMPARE_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_STEP = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // slow time base divides the bus clock by eight
  localparam int PRESCALE_DIV = 8;
  localparam int PRESCALE_W = 3;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 3'h7;
  localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 3'h0;

  // control register contents
  typedef struct packed {
    logic soft_irq_request;
    logic auto_reload_enable;
    logic time_base_select;
    logic counter_irq_enable;
    logic counter_enable;
  } control_s;

  localparam control_s CONTROL_RST = '{default: 1'b0};

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] byteenable;
    logic [DATA_W-1:0] writedata;
  } avs_req_s;

  // avalon-mm answer to the master
  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
  } avs_rsp_s;

  localparam avs_rsp_s AVS_RSP_RST = '{readdata: 32'h0000_0000, waitrequest: 1'b1};

  typedef logic [DATA_W-1:0] word_t;

endpackage : tick_pkg

//--- logic/tick_prescaler.sv
// time base generator: one tick per clock or one per eight clocks
`timescale 1ns/100ps
module tick_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic fast_select,
  // time base
  output logic tick
);
  import tick_pkg::*;

  logic [PRESCALE_W-1:0] div_q;
  logic [PRESCALE_W-1:0] div_d;

  // divider restarts whenever counting is off, so the first slow tick is eight clocks out
  always_comb begin
    div_d = div_q;
    if (!enable || fast_select) begin
      div_d = PRESCALE_ZERO;
    end else begin
      div_d = div_q + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= PRESCALE_ZERO;
    end else begin
      div_q <= div_d;
    end
  end

  // combinational so that clearing enable stops the very next step
  assign tick = enable && (fast_select || (div_q == PRESCALE_LAST)); // see R5

endmodule : tick_prescaler
